// File: rtl/pin_select_pkg.sv
// Package with register map, field layout and source codes for input pin select
package pin_select_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int FIELD_W = 7;
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 8;
  localparam int NUM_REGS = 12;
  localparam int NUM_SRC = 128;
  localparam logic [ADDR_W-1:0] UART1_RX_SOURCE_SELECT = 4'h0;
  localparam logic [ADDR_W-1:0] UART2_RX_SOURCE_SELECT = 4'h1;
  localparam logic [ADDR_W-1:0] SPI2_CLOCK_DATA_SOURCE_SELECT = 4'h2;
  localparam logic [ADDR_W-1:0] SPI2_SLAVE_SELECT_SOURCE = 4'h3;
  localparam logic [ADDR_W-1:0] CODEC_CLOCK_DATA_SOURCE_SELECT = 4'h4;
  localparam logic [ADDR_W-1:0] CODEC_FRAME_SYNC_SOURCE_SELECT = 4'h5;
  localparam logic [ADDR_W-1:0] CAN_RX_SOURCE_SELECT = 4'h6;
  localparam logic [ADDR_W-1:0] UART3_RX_CTS_SOURCE_SELECT = 4'h7;
  localparam logic [ADDR_W-1:0] UART4_RX_CTS_SOURCE_SELECT = 4'h8;
  localparam logic [ADDR_W-1:0] SPI3_CLOCK_DATA_SOURCE_SELECT = 4'h9;
  localparam logic [ADDR_W-1:0] SPI3_SLAVE_SELECT_SOURCE = 4'ha;
  localparam logic [ADDR_W-1:0] PWM_SYNC_IN1_SOURCE_SELECT = 4'hb;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  // Writable masks: low field, high field, or both
  localparam logic [DATA_W-1:0] MASK_LO = 16'h007f;
  localparam logic [DATA_W-1:0] MASK_HI = 16'h7f00;
  localparam logic [DATA_W-1:0] MASK_BOTH = 16'h7f7f;
  localparam logic [FIELD_W-1:0] SRC_LOW = 7'h00;
  localparam logic [FIELD_W-1:0] SRC_COMPARATOR_ONE_OUTPUT = 7'h01;
  localparam logic [FIELD_W-1:0] SRC_MAX_STD = 7'h7c;
  localparam logic [FIELD_W-1:0] SRC_MAX_EXT = 7'h7f;

  typedef struct packed {
    logic uart1_rx;
    logic uart2_rx;
    logic spi2_clk;
    logic spi2_din;
    logic spi2_ss;
    logic codec_clk;
    logic codec_din;
    logic codec_frame;
    logic can1_rx;
    logic can2_rx;
    logic uart3_rx;
    logic uart3_cts;
    logic uart4_rx;
    logic uart4_cts;
    logic spi3_clk;
    logic spi3_din;
    logic spi3_ss;
    logic pwm_sync_in1;
  } periph_in_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage

// File: rtl/source_mux.sv
// One selection field picking a source among constant low, comparator and pins
`timescale 1ns/10ps
module source_mux
  import pin_select_pkg::*;
#(
  parameter logic [FIELD_W-1:0] MAX_CODE = SRC_MAX_STD
) (
  input wire logic [FIELD_W-1:0] sel_i,
  input wire logic comparator_one_output_i,
  input wire logic [NUM_SRC-1:0] remappable_pin_i,
  output logic src_o
);
  always_comb begin
    if (sel_i == SRC_LOW) begin
      src_o = 1'b0;
    end else if (sel_i == SRC_COMPARATOR_ONE_OUTPUT) begin
      src_o = comparator_one_output_i;
    end else if (sel_i > MAX_CODE) begin
      // Codes beyond the range have no pin; held low
      src_o = 1'b0;
    end else begin
      src_o = remappable_pin_i[sel_i];
    end
  end
endmodule

// File: rtl/sel_reg.sv
// One selection register with masked write and reset to the low source
`timescale 1ns/10ps
module sel_reg
  import pin_select_pkg::*;
#(
  parameter logic [DATA_W-1:0] MASK = MASK_LO
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic we_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic [DATA_W-1:0] q_o
);
  logic [DATA_W-1:0] val_ff;
  logic [DATA_W-1:0] nxt_val;

  always_comb begin
    nxt_val = val_ff;
    if (we_i) begin
      nxt_val = wdata_i & MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      val_ff <= REG_RESET;
    end else begin
      val_ff <= nxt_val;
    end
  end

  assign q_o = val_ff;
endmodule

// File: rtl/peripheral_input_pin_select.sv
// Top of the peripheral input pin select: registers, read port and routing
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
module peripheral_input_pin_select
  import pin_select_pkg::*;
#(
  parameter bit HAS_CAN = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic comparator_one_output_i,
  input wire logic [NUM_SRC-1:0] remappable_pin_i,
  output periph_in_s periph_o
);
  localparam logic [DATA_W-1:0] MASKS [NUM_REGS] = '{
    MASK_LO, MASK_LO, MASK_BOTH, MASK_LO, MASK_BOTH, MASK_LO,
    MASK_BOTH, MASK_BOTH, MASK_BOTH, MASK_BOTH, MASK_LO, MASK_HI};

  logic [DATA_W-1:0] regs [NUM_REGS];
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  periph_in_s periph_ff;
  periph_in_s nxt_periph;

  function automatic logic [FIELD_W-1:0] lo_f(input logic [DATA_W-1:0] r);
    lo_f = r[LO_LSB +: FIELD_W];
  endfunction

  function automatic logic [FIELD_W-1:0] hi_f(input logic [DATA_W-1:0] r);
    hi_f = r[HI_LSB +: FIELD_W];
  endfunction

  function automatic logic reg_present(input logic [ADDR_W-1:0] a);
    reg_present = (a < ADDR_W'(NUM_REGS)) && (HAS_CAN || a != CAN_RX_SOURCE_SELECT);
  endfunction

  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    if (g == int'(CAN_RX_SOURCE_SELECT) && !HAS_CAN) begin : g_none
      assign regs[g] = REG_RESET;
    end else begin : g_impl
      sel_reg #(
        .MASK(MASKS[g])
      ) u_reg (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .we_i(wr_i && addr_i == ADDR_W'(g)),
        .wdata_i(wdata_i),
        .q_o(regs[g])
      );
    end
  end

  // Eighteen field selections in struct order
  logic [FIELD_W-1:0] sel [18];
  logic [17:0] src;
  assign sel[0] = lo_f(regs[UART1_RX_SOURCE_SELECT]);
  assign sel[1] = lo_f(regs[UART2_RX_SOURCE_SELECT]);
  assign sel[2] = hi_f(regs[SPI2_CLOCK_DATA_SOURCE_SELECT]);
  assign sel[3] = lo_f(regs[SPI2_CLOCK_DATA_SOURCE_SELECT]);
  assign sel[4] = lo_f(regs[SPI2_SLAVE_SELECT_SOURCE]);
  assign sel[5] = hi_f(regs[CODEC_CLOCK_DATA_SOURCE_SELECT]);
  assign sel[6] = lo_f(regs[CODEC_CLOCK_DATA_SOURCE_SELECT]);
  assign sel[7] = lo_f(regs[CODEC_FRAME_SYNC_SOURCE_SELECT]);
  assign sel[8] = lo_f(regs[CAN_RX_SOURCE_SELECT]);
  assign sel[9] = hi_f(regs[CAN_RX_SOURCE_SELECT]);
  assign sel[10] = lo_f(regs[UART3_RX_CTS_SOURCE_SELECT]);
  assign sel[11] = hi_f(regs[UART3_RX_CTS_SOURCE_SELECT]);
  assign sel[12] = lo_f(regs[UART4_RX_CTS_SOURCE_SELECT]);
  assign sel[13] = hi_f(regs[UART4_RX_CTS_SOURCE_SELECT]);
  assign sel[14] = hi_f(regs[SPI3_CLOCK_DATA_SOURCE_SELECT]);
  assign sel[15] = lo_f(regs[SPI3_CLOCK_DATA_SOURCE_SELECT]);
  assign sel[16] = lo_f(regs[SPI3_SLAVE_SELECT_SOURCE]);
  assign sel[17] = hi_f(regs[PWM_SYNC_IN1_SOURCE_SELECT]);

  for (genvar m = 0; m < 18; m++) begin : g_mux
    localparam bit EXT = (m >= 10 && m <= 13) || m == 16;
    source_mux #(
      .MAX_CODE(EXT ? SRC_MAX_EXT : SRC_MAX_STD)
    ) u_mux (
      .sel_i(sel[m]),
      .comparator_one_output_i(comparator_one_output_i),
      .remappable_pin_i(remappable_pin_i),
      .src_o(src[17-m])
    );
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_i) begin
      // Unmapped or absent addresses read zero
      nxt_rdata = reg_present(addr_i) ? regs[addr_i] : REG_RESET;
    end
    // Output flop costs one cycle of latency on every peripheral input
    nxt_periph = src;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_ff <= REG_RESET;
      periph_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
      periph_ff <= nxt_periph;
    end
  end

  assign rdata_o = rdata_ff;
  assign periph_o = periph_ff;

  AST_UNIMPL_ZERO: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $past(rd_i) |-> (rdata_o & ~MASK_BOTH) == '0)
    else $error("unimplemented bits read nonzero");
  AST_LOW_SRC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sel[0] == SRC_LOW |=> !periph_o.uart1_rx)
    else $error("low source not low");
  AST_CMP_SRC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sel[7] == SRC_COMPARATOR_ONE_OUTPUT |=> periph_o.codec_frame == $past(comparator_one_output_i))
    else $error("comparator route wrong");
  AST_PIN124: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sel[1] == SRC_MAX_STD |=> periph_o.uart2_rx == $past(remappable_pin_i[124]))
    else $error("pin 124 route wrong");
  AST_EXT127: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sel[16] == SRC_MAX_EXT |=> periph_o.spi3_ss == $past(remappable_pin_i[127]))
    else $error("extended code route wrong");
  AST_CODEC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rd_i && addr_i == CODEC_CLOCK_DATA_SOURCE_SELECT |=> rdata_o[6:0] == $past(sel[6]))
    else $error("codec field readback wrong");
  AST_CAN2: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sel[9] == SRC_COMPARATOR_ONE_OUTPUT |=> periph_o.can2_rx == $past(comparator_one_output_i))
    else $error("can2 route wrong");
  AST_NOCAN: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !HAS_CAN |-> sel[8] == SRC_LOW && sel[9] == SRC_LOW)
    else $error("absent can register not zero");
  AST_WRRD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_i && addr_i == UART1_RX_SOURCE_SELECT ##1 rd_i && addr_i == UART1_RX_SOURCE_SELECT
    |=> rdata_o == ($past(wdata_i, 2) & MASK_LO))
    else $error("write readback mismatch");
endmodule

// File: tb/peripheral_input_pin_select_tb_top.sv
// Self-checking bench for the peripheral input pin select
`timescale 1ns/10ps
module peripheral_input_pin_select_tb_top;
  import pin_select_pkg::*;
  typedef struct packed {logic [3:0] a; logic [15:0] w; logic [15:0] r;} row_s;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic cmp_i = 1'b0;
  logic [NUM_SRC-1:0] pin_i = '0;
  periph_in_s periph_o;
  // Variant without the CAN register shares every input
  logic [DATA_W-1:0] nocan_rdata;
  periph_in_s nocan_periph;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  // Address, write value, expected read-back
  row_s rows [8] = '{'{4'h0, 16'hffff, 16'h007f}, '{4'h1, 16'h8080, 16'h0000},
    '{4'h2, 16'hffff, 16'h7f7f}, '{4'h4, 16'hff80, 16'h7f00},
    '{4'h6, 16'h7f7f, 16'h7f7f}, '{4'hb, 16'hffff, 16'h7f00},
    '{4'ha, 16'h00ff, 16'h007f}, '{4'hc, 16'hffff, 16'h0000}};

  peripheral_input_pin_select dut_u (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .comparator_one_output_i(cmp_i),
    .remappable_pin_i(pin_i),
    .periph_o(periph_o)
  );

  peripheral_input_pin_select #(
    .HAS_CAN(1'b0)
  ) nocan_u (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(nocan_rdata),
    .comparator_one_output_i(cmp_i),
    .remappable_pin_i(pin_i),
    .periph_o(nocan_periph)
  );

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Cut a hang short well beyond the expected run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(32'(rdata_o), 32'(e));
  endtask

  // Register stage then output flop before the routed level shows
  task automatic route(input logic [3:0] a, input logic [15:0] d,
                       input logic [127:0] pv, input logic c);
    @(posedge clk_i);
    pin_i <= pv;
    cmp_i <= c;
    wr(a, d);
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 12; i++) rd(4'(i), 16'h0000);
    chk(32'(periph_o), 32'h0);
    $display("reset values done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r);
    end
    $display("register rows done");
    route(4'h0, 16'h0000, '1, 1'b1);
    chk(32'(periph_o.uart1_rx), 32'h0);
    route(4'h0, 16'h0001, '0, 1'b1);
    chk(32'(periph_o.uart1_rx), 32'h1);
    route(4'h0, 16'h007c, 128'(1) << 124, 1'b0);
    chk(32'(periph_o.uart1_rx), 32'h1);
    route(4'h0, 16'h007f, 128'(1) << 127, 1'b0);
    chk(32'(periph_o.uart1_rx), 32'h0);
    route(4'h7, 16'h7f7f, 128'(1) << 127, 1'b0);
    chk(32'({periph_o.uart3_rx, periph_o.uart3_cts}), 32'h3);
    route(4'ha, 16'h007f, 128'(1) << 127, 1'b0);
    chk(32'(periph_o.spi3_ss), 32'h1);
    route(4'h4, 16'h0506, 128'(1) << 6, 1'b0);
    chk(32'({periph_o.codec_clk, periph_o.codec_din}), 32'h1);
    route(4'h6, 16'h0506, 128'(1) << 6, 1'b0);
    chk(32'({periph_o.can2_rx, periph_o.can1_rx}), 32'h1);
    rd(4'h6, 16'h0506);
    chk(32'(nocan_rdata), 32'h0);
    chk(32'({nocan_periph.can2_rx, nocan_periph.can1_rx}), 32'h0);
    route(4'h6, 16'h0100, '0, 1'b1);
    chk(32'({periph_o.can2_rx, periph_o.can1_rx}), 32'h2);
    route(4'h5, 16'h0001, '0, 1'b1);
    chk(32'(periph_o.codec_frame), 32'h1);
    route(4'h1, 16'h007c, 128'(1) << 124, 1'b0);
    chk(32'(periph_o.uart2_rx), 32'h1);
    route(4'hb, 16'h0500, 128'(1) << 5, 1'b0);
    chk(32'(periph_o.pwm_sync_in1), 32'h1);
    // Pin level change alone must reach the peripheral
    @(posedge clk_i);
    pin_i <= '0;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(32'(periph_o.pwm_sync_in1), 32'h0);
    // Write then read with no gap between the strobes
    @(posedge clk_i);
    addr_i <= 4'h0;
    wdata_i <= 16'h0123;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(32'(rdata_o), 32'h0023);
    $display("routing done");
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(4'h6, 16'h0000);
    chk(32'(periph_o), 32'h0);
    $display("second reset done");
    give_verdict();
  end
endmodule
